// ### rtl/dct_clock_tuning_regs.sv
// sample-clock tuning register bank with decoded controls
// Notes on behaviour
// - duty bit 7 enables correction, resets 1
// - duty bit 6 gates offset trim, resets 0
// - duty bit 5 widens range to five percent
// - trim bits 4:0 are sign-magnitude, -15 to 15
// - crossing bit 7 enables adjustment, resets 1
// - crossing bits 3:0 set adjustment, reset 0
// - rate bits 5:4 pick reference multiplier
// - reference bit 0 powers reference down
// - strobe bit 3 enables programmed hysteresis
// - strobe bit 2 selects rising edge sampling
// - ten-bit hysteresis split, 10 mV per step
// - four delay-loop path enables, each reset 1
// - delay-loop bit 0 powers down, resets 1
`timescale 1ns/1ps
module dct_clock_tuning_regs
  import dct_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic [DCT_AW-1:0] reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic [DCT_DW-1:0] reg_wdata_in,
  input  wire logic              reg_rd_in,
  output logic      [DCT_DW-1:0] reg_rdata_out,
  output logic                   reg_rvalid_out,
  output logic                   duty_fix_on_out,
  output logic                   duty_offset_on_out,
  output logic                   duty_boost_on_out,
  output logic             [4:0] duty_trim_value_out,
  output logic signed      [4:0] duty_skew_out,
  output logic             [2:0] duty_range_pct_out,
  output logic                   crossing_adjust_on_out,
  output logic             [3:0] crossing_adjust_value_out,
  output logic             [1:0] ref_rate_sel_out,
  output logic             [2:0] ref_multiplier_out,
  output logic                   reference_power_off_out,
  output logic                   ref_clock_active_out,
  output logic                   strobe_hysteresis_on_out,
  output logic                   strobe_rising_edge_select_out,
  output logic             [9:0] strobe_hysteresis_amount_out,
  output logic            [13:0] strobe_hysteresis_mv_out,
  output logic                   fine_line_duty_fix_on_out,
  output logic                   fine_line_cross_fix_on_out,
  output logic                   coarse_line_duty_fix_on_out,
  output logic                   coarse_line_cross_fix_on_out,
  output logic                   delay_loop_power_off_out
);

  logic [DCT_DW-1:0]    bank_q [DCT_NREGS];
  logic [DCT_NREGS-1:0] hit;
  logic [DCT_DW-1:0]    next_rdata;
  logic [2:0]           next_mult;
  logic [9:0]           hys_amount;

  dct_duty_if dif ();

  // one storage register per entry
  for (genvar i = 0; i < DCT_NREGS; i++) begin : g_reg
    assign hit[i] = (reg_addr_in == DCT_OFFS[i*8 +: 8]);

    always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
        bank_q[i] <= DCT_RSTS[i*8 +: 8];
      end else if (reg_wr_in && hit[i]) begin
        bank_q[i] <= reg_wdata_in & DCT_MSKS[i*8 +: 8];
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    for (int j = 0; j < DCT_NREGS; j++) begin
      if (hit[j]) begin
        next_rdata = bank_q[j];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'h0;
    end else begin
      reg_rdata_out  <= reg_rd_in ? next_rdata : 8'h00;
      reg_rvalid_out <= reg_rd_in;
    end
  end

  assign duty_fix_on_out     = bank_q[DCT_I_DUTY][DCT_B_DUTY_ON];
  assign duty_offset_on_out  = bank_q[DCT_I_DUTY][DCT_B_DUTY_OFS];
  assign duty_boost_on_out   = bank_q[DCT_I_DUTY][DCT_B_DUTY_BST];
  assign duty_trim_value_out = bank_q[DCT_I_DUTY][4:0];

  assign dif.duty_on    = duty_fix_on_out;
  assign dif.offset_on  = duty_offset_on_out;
  assign dif.boost_on   = duty_boost_on_out;
  assign dif.trim_value = duty_trim_value_out;

  dct_duty_dec u_dec (
    .dif (dif.dec)
  );

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      duty_skew_out      <= 5'sh00;
      duty_range_pct_out <= DCT_RANGE_NORM_PCT;
    end else begin
      duty_skew_out      <= dif.skew;
      duty_range_pct_out <= dif.range_pct;
    end
  end

  assign crossing_adjust_on_out    = bank_q[DCT_I_CRS][DCT_B_CRS_ON];
  assign crossing_adjust_value_out = bank_q[DCT_I_CRS][3:0];

  assign ref_rate_sel_out =
    bank_q[DCT_I_REF][DCT_B_RATE_LO +: 2];
  assign reference_power_off_out = bank_q[DCT_I_REF][DCT_B_REF_PD];

  always_comb begin
    case (ref_rate_sel_out)
      DCT_RATE_X1: next_mult = DCT_MULT_X1;
      DCT_RATE_X2: next_mult = DCT_MULT_X2;
      DCT_RATE_X4: next_mult = DCT_MULT_X4;
      default:     next_mult = DCT_MULT_OFF;
    endcase
  end

  // power-down or code 11 stops reference
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ref_multiplier_out   <= DCT_MULT_X1;
      ref_clock_active_out <= 1'h1;
    end else begin
      ref_multiplier_out   <= reference_power_off_out ? DCT_MULT_OFF
                                                      : next_mult;
      ref_clock_active_out <= !reference_power_off_out &&
                              (ref_rate_sel_out != DCT_RATE_OFF);
    end
  end

  assign strobe_hysteresis_on_out =
    bank_q[DCT_I_SYS0][DCT_B_STROBE_HYSTERESIS_ON];
  assign strobe_rising_edge_select_out =
    bank_q[DCT_I_SYS0][DCT_B_RISE];
  assign hys_amount = {bank_q[DCT_I_SYS0][1:0], bank_q[DCT_I_SYS1]};
  assign strobe_hysteresis_amount_out = hys_amount;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      strobe_hysteresis_mv_out <= 14'h0000;
    end else if (strobe_hysteresis_on_out) begin
      strobe_hysteresis_mv_out <= {4'h0, hys_amount} * DCT_HYS_MV_STEP;
    end else begin
      strobe_hysteresis_mv_out <= 14'h0000;
    end
  end

  assign fine_line_duty_fix_on_out    = bank_q[DCT_I_DLL][DCT_B_FINE_DC];
  assign fine_line_cross_fix_on_out   = bank_q[DCT_I_DLL][DCT_B_FINE_XC];
  assign coarse_line_duty_fix_on_out  = bank_q[DCT_I_DLL][DCT_B_CRS_DC];
  assign coarse_line_cross_fix_on_out = bank_q[DCT_I_DLL][DCT_B_CRS_XC];
  assign delay_loop_power_off_out     = bank_q[DCT_I_DLL][DCT_B_DELAY_LOOP_POWER];

  // checks
  sequence s_wr_duty;
    reg_wr_in && reg_addr_in == DCT_OFF_DUTY;
  endsequence

  sequence s_wr_dll;
    reg_wr_in && reg_addr_in == DCT_OFF_DLL;
  endsequence

  sequence s_rd_crs;
    reg_rd_in && reg_addr_in == DCT_OFF_CRS;
  endsequence

  sequence s_wr_crs;
    reg_wr_in && reg_addr_in == DCT_OFF_CRS;
  endsequence

  sequence s_wr_ref;
    reg_wr_in && reg_addr_in == DCT_OFF_REF;
  endsequence

  sequence s_wr_sys0;
    reg_wr_in && reg_addr_in == DCT_OFF_SYS0;
  endsequence

  sequence s_wr_sys1;
    reg_wr_in && reg_addr_in == DCT_OFF_SYS1;
  endsequence

  reset_values_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    $past(srst_in) |-> bank_q[DCT_I_DUTY] == DCT_RST_DUTY &&
      bank_q[DCT_I_CRS] == DCT_RST_CRS && bank_q[DCT_I_DLL] == DCT_RST_DLL
      && delay_loop_power_off_out && !duty_offset_on_out)
    else $error("bank not at reset values after reset");

  duty_write_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_duty |=> duty_fix_on_out == $past(reg_wdata_in[7]) &&
      duty_offset_on_out == $past(reg_wdata_in[6]))
    else $error("duty enable bits did not take write");

  skew_decode_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_duty ##1 (!reg_wr_in && duty_fix_on_out && duty_offset_on_out)
      |=> duty_skew_out == (duty_trim_value_out[4]
          ? -$signed({1'h0, duty_trim_value_out[3:0]})
          : $signed({1'h0, duty_trim_value_out[3:0]})))
    else $error("duty skew does not match trim field");

  boost_range_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    duty_boost_on_out ##1 duty_boost_on_out |->
      duty_range_pct_out == DCT_RANGE_BOOST_PCT)
    else $error("boost did not widen range");

  reserved_zero_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_rd_crs |=> reg_rvalid_out && reg_rdata_out[6:4] == 3'h0)
    else $error("reserved crossing bits read nonzero");

  hold_value_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    !reg_wr_in |=> $stable(bank_q[DCT_I_SYS0]) &&
      $stable(bank_q[DCT_I_SYS1]) && $stable(bank_q[DCT_I_REF]))
    else $error("register changed without a write");

  ref_stop_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    (reference_power_off_out || ref_rate_sel_out == DCT_RATE_OFF)
      |=> !ref_clock_active_out && ref_multiplier_out == DCT_MULT_OFF)
    else $error("reference active while disabled");

  ref_double_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    (!reference_power_off_out && ref_rate_sel_out == DCT_RATE_X2)
      |=> ref_multiplier_out == DCT_MULT_X2 && ref_clock_active_out)
    else $error("double rate not decoded");

  hys_applied_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    ##1 strobe_hysteresis_mv_out == ($past(strobe_hysteresis_on_out)
      ? {4'h0, $past(hys_amount)} * DCT_HYS_MV_STEP : 14'h0000))
    else $error("applied hysteresis mV wrong");

  dll_power_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_dll |=> delay_loop_power_off_out == $past(reg_wdata_in[0]) &&
      fine_line_duty_fix_on_out == $past(reg_wdata_in[4]))
    else $error("delay loop control not written");

  crossing_write_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_crs |=> crossing_adjust_on_out == $past(reg_wdata_in[7]) &&
      crossing_adjust_value_out == $past(reg_wdata_in[3:0]))
    else $error("crossing fields did not take write");

  ref_write_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_ref |=> ref_rate_sel_out == $past(reg_wdata_in[5:4]) &&
      reference_power_off_out == $past(reg_wdata_in[0]))
    else $error("reference fields did not take write");

  strobe_write_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_sys0 |=> strobe_rising_edge_select_out == $past(reg_wdata_in[2])
      && strobe_hysteresis_on_out == $past(reg_wdata_in[3]))
    else $error("strobe control bits did not take write");

  hys_low_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_sys1 |=> strobe_hysteresis_amount_out[7:0] == $past(reg_wdata_in)
      && $stable(strobe_hysteresis_amount_out[9:8]))
    else $error("hysteresis low byte did not take write");

  loop_paths_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_wr_dll |=> {fine_line_duty_fix_on_out, fine_line_cross_fix_on_out,
      coarse_line_duty_fix_on_out, coarse_line_cross_fix_on_out}
      == $past(reg_wdata_in[4:1]))
    else $error("delay loop path enables not written");

  read_data_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    s_rd_crs |=> reg_rdata_out == $past(bank_q[DCT_I_CRS]))
    else $error("read data differs from held value");

  ref_reserved_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    (reg_rd_in && reg_addr_in == DCT_OFF_REF) |=>
      reg_rdata_out[7:6] == 2'h0 && reg_rdata_out[3:1] == 3'h0)
    else $error("reserved reference bits read nonzero");

  unmapped_read_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    (reg_rd_in && hit == '0) |=> reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("unmapped read returned data");

  range_norm_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    !duty_boost_on_out |=> duty_range_pct_out == DCT_RANGE_NORM_PCT)
    else $error("range widened without boost");

  skew_gated_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    !duty_offset_on_out |=> duty_skew_out == 5'sh00)
    else $error("skew applied with offset gate off");

endmodule : dct_clock_tuning_regs

// ### rtl/dct_pkg.sv
// constants for the sample-clock tuning register bank
package dct_pkg;

  localparam int          DCT_NREGS  = 6;
  localparam int          DCT_AW     = 8;
  localparam int          DCT_DW     = 8;

  // register indices
  localparam int          DCT_I_DUTY = 0;
  localparam int          DCT_I_CRS  = 1;
  localparam int          DCT_I_REF  = 2;
  localparam int          DCT_I_SYS0 = 3;
  localparam int          DCT_I_SYS1 = 4;
  localparam int          DCT_I_DLL  = 5;

  // register offsets
  localparam logic [7:0]  DCT_OFF_DUTY = 8'h82;
  localparam logic [7:0]  DCT_OFF_CRS  = 8'h83;
  localparam logic [7:0]  DCT_OFF_REF  = 8'h84;
  localparam logic [7:0]  DCT_OFF_SYS0 = 8'h88;
  localparam logic [7:0]  DCT_OFF_SYS1 = 8'h89;
  localparam logic [7:0]  DCT_OFF_DLL  = 8'h90;

  // reset values
  localparam logic [7:0]  DCT_RST_DUTY = 8'h80;
  localparam logic [7:0]  DCT_RST_CRS  = 8'h80;
  localparam logic [7:0]  DCT_RST_REF  = 8'h00;
  localparam logic [7:0]  DCT_RST_SYS0 = 8'h00;
  localparam logic [7:0]  DCT_RST_SYS1 = 8'h00;
  localparam logic [7:0]  DCT_RST_DLL  = 8'h1F;

  // writable bits, reserved bits are zero here
  localparam logic [7:0]  DCT_MSK_DUTY = 8'hFF;
  localparam logic [7:0]  DCT_MSK_CRS  = 8'h8F;
  localparam logic [7:0]  DCT_MSK_REF  = 8'h31;
  localparam logic [7:0]  DCT_MSK_SYS0 = 8'h0F;
  localparam logic [7:0]  DCT_MSK_SYS1 = 8'hFF;
  localparam logic [7:0]  DCT_MSK_DLL  = 8'h1F;

  // tables indexed by register index, entry 0 in the low byte
  localparam logic [47:0] DCT_OFFS = {DCT_OFF_DLL, DCT_OFF_SYS1,
    DCT_OFF_SYS0, DCT_OFF_REF, DCT_OFF_CRS, DCT_OFF_DUTY};
  localparam logic [47:0] DCT_RSTS = {DCT_RST_DLL, DCT_RST_SYS1,
    DCT_RST_SYS0, DCT_RST_REF, DCT_RST_CRS, DCT_RST_DUTY};
  localparam logic [47:0] DCT_MSKS = {DCT_MSK_DLL, DCT_MSK_SYS1,
    DCT_MSK_SYS0, DCT_MSK_REF, DCT_MSK_CRS, DCT_MSK_DUTY};

  // field positions
  localparam int          DCT_B_DUTY_ON   = 7;
  localparam int          DCT_B_DUTY_OFS  = 6;
  localparam int          DCT_B_DUTY_BST  = 5;
  localparam int          DCT_B_TRIM_SIGN = 4;
  localparam int          DCT_B_CRS_ON    = 7;
  localparam int          DCT_B_RATE_LO   = 4;
  localparam int          DCT_B_REF_PD    = 0;
  localparam int          DCT_B_STROBE_HYSTERESIS_ON    = 3;
  localparam int          DCT_B_RISE      = 2;
  localparam int          DCT_B_FINE_DC   = 4;
  localparam int          DCT_B_FINE_XC   = 3;
  localparam int          DCT_B_CRS_DC    = 2;
  localparam int          DCT_B_CRS_XC    = 1;
  localparam int          DCT_B_DELAY_LOOP_POWER    = 0;

  // reference rate codes and multipliers
  localparam logic [1:0]  DCT_RATE_X1  = 2'h0;
  localparam logic [1:0]  DCT_RATE_X2  = 2'h1;
  localparam logic [1:0]  DCT_RATE_X4  = 2'h2;
  localparam logic [1:0]  DCT_RATE_OFF = 2'h3;
  localparam logic [2:0]  DCT_MULT_X1  = 3'h1;
  localparam logic [2:0]  DCT_MULT_X2  = 3'h2;
  localparam logic [2:0]  DCT_MULT_X4  = 3'h4;
  localparam logic [2:0]  DCT_MULT_OFF = 3'h0;

  // analog scale figures
  localparam logic [2:0]  DCT_RANGE_NORM_PCT  = 3'h3;
  localparam logic [2:0]  DCT_RANGE_BOOST_PCT = 3'h5;
  localparam logic [13:0] DCT_HYS_MV_STEP     = 14'h000A;

endpackage : dct_pkg

// ### rtl/dct_duty_if.sv
// duty trim fields and decoded skew between bank and decoder
`timescale 1ns/1ps
interface dct_duty_if;
  logic              duty_on;
  logic              offset_on;
  logic              boost_on;
  logic        [4:0] trim_value;
  logic signed [4:0] skew;
  logic        [2:0] range_pct;

  modport bank (output duty_on, offset_on, boost_on, trim_value,
                input  skew, range_pct);
  modport dec  (input  duty_on, offset_on, boost_on, trim_value,
                output skew, range_pct);
endinterface : dct_duty_if

// ### rtl/dct_duty_dec.sv
// sign-magnitude duty trim decoder
`timescale 1ns/1ps
module dct_duty_dec
  import dct_pkg::*;
(
  dct_duty_if.dec dif
);

  logic [3:0] mag;

  assign mag = dif.trim_value[3:0];

  always_comb begin
    if (!dif.duty_on || !dif.offset_on) begin
      dif.skew = 5'sh00;
    end else if (dif.trim_value[DCT_B_TRIM_SIGN]) begin
      dif.skew = -$signed({1'h0, mag});
    end else begin
      dif.skew = $signed({1'h0, mag});
    end
  end

  assign dif.range_pct = dif.boost_on ? DCT_RANGE_BOOST_PCT
                                      : DCT_RANGE_NORM_PCT;

endmodule : dct_duty_dec

// ### verification/dct_clock_tuning_regs_tb_top.sv
// self-checking bench for the sample-clock tuning register bank
`timescale 1ns/1ps
module dct_clock_tuning_regs_tb_top import dct_pkg::*;;
  logic              clk;
  logic              rst;
  logic        [7:0] addr;
  logic              wr;
  logic        [7:0] wdata;
  logic              rd;
  logic        [7:0] rdata;
  logic              rvalid;
  logic              d_on, d_ofs, d_bst, c_on, r_pd, r_act, h_on, h_rise;
  logic        [4:0] d_trim;
  logic signed [4:0] d_skew;
  logic        [2:0] d_rng, r_mul;
  logic        [3:0] c_val;
  logic        [1:0] r_sel;
  logic        [9:0] h_amt;
  logic       [13:0] h_mv;
  logic              f_dc, f_xc, k_dc, k_xc, l_pd;
  int                errors = 0;
  int                compares = 0;
  logic        [7:0] offs [6] = '{8'h82, 8'h83, 8'h84, 8'h88, 8'h89, 8'h90};
  logic        [7:0] rsts [6] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h1F};
  logic        [7:0] msks [6] = '{8'hFF, 8'h8F, 8'h31, 8'h0F, 8'hFF, 8'h1F};
  logic        [2:0] mults [4] = '{3'h1, 3'h2, 3'h4, 3'h0};

  initial clk = 1'b0;
  always #50 clk = ~clk;

  dct_clock_tuning_regs uut (.sys_clk_in(clk), .srst_in(rst),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .duty_fix_on_out(d_on), .duty_offset_on_out(d_ofs),
    .duty_boost_on_out(d_bst), .duty_trim_value_out(d_trim),
    .duty_skew_out(d_skew), .duty_range_pct_out(d_rng),
    .crossing_adjust_on_out(c_on), .crossing_adjust_value_out(c_val),
    .ref_rate_sel_out(r_sel), .ref_multiplier_out(r_mul),
    .reference_power_off_out(r_pd), .ref_clock_active_out(r_act),
    .strobe_hysteresis_on_out(h_on),
    .strobe_rising_edge_select_out(h_rise),
    .strobe_hysteresis_amount_out(h_amt), .strobe_hysteresis_mv_out(h_mv),
    .fine_line_duty_fix_on_out(f_dc), .fine_line_cross_fix_on_out(f_xc),
    .coarse_line_duty_fix_on_out(k_dc),
    .coarse_line_cross_fix_on_out(k_xc),
    .delay_loop_power_off_out(l_pd));

  task automatic chk(input logic [13:0] got, input logic [13:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
    wdata = ~d;
    @(negedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    chk({13'h0, rvalid}, 14'h0001, "read valid");
    v    = rdata;
    @(negedge clk);
    chk({13'h0, rvalid}, 14'h0000, "valid one cycle");
  endtask : rd_reg

  task automatic reset_values;
    logic [7:0] v;
    @(negedge clk);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(offs[i], v);
      chk({6'h0, v}, {6'h0, rsts[i]}, "reset value");
    end
    chk({9'h0, d_on, d_ofs, d_bst, c_on, r_pd}, 14'h0012, "rst flags");
    chk({9'h0, f_dc, f_xc, k_dc, k_xc, l_pd}, 14'h001F, "rst loop");
    chk({10'h0, c_val}, 14'h0000, "reset crossing");
    chk({11'h0, r_mul}, 14'h0001, "reset multiplier");
  endtask : reset_values

  task automatic reserved_bits;
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      wr_reg(offs[i], 8'hFF);
      rd_reg(offs[i], v);
      chk({6'h0, v}, {6'h0, msks[i]}, "ones masked");
      wr_reg(offs[i], 8'h00);
      rd_reg(offs[i], v);
      chk({6'h0, v}, 14'h0000, "zeros held");
    end
    wr_reg(8'h85, 8'hFF);
    rd_reg(8'h85, v);
    chk({6'h0, v}, 14'h0000, "unmapped read");
  endtask : reserved_bits

  task automatic duty_trim;
    wr_reg(8'h82, 8'hDF);
    chk({9'h0, d_skew}, 14'h0011, "skew minus 15");
    chk({11'h0, d_rng}, 14'h0003, "normal range");
    chk({9'h0, d_trim}, 14'h001F, "raw trim");
    wr_reg(8'h82, 8'hE5);
    chk({9'h0, d_skew}, 14'h0005, "skew plus 5");
    chk({11'h0, d_rng}, 14'h0005, "boost range");
    chk({11'h0, d_on, d_ofs, d_bst}, 14'h0007, "duty flags");
    wr_reg(8'h82, 8'h9F);
    chk({9'h0, d_skew}, 14'h0000, "offset gated");
    chk({11'h0, d_on, d_ofs, d_bst}, 14'h0004, "offset off");
    wr_reg(8'h82, 8'h5F);
    chk({13'h0, d_on}, 14'h0000, "correction off");
    chk({9'h0, d_skew}, 14'h0000, "skew when off");
  endtask : duty_trim

  task automatic ref_rates;
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h84, {2'h0, 2'(c), 4'h0});
      chk({12'h0, r_sel}, 14'(c), "rate code");
      chk({11'h0, r_mul}, {11'h0, mults[c]}, "multiplier");
      chk({13'h0, r_act}, {13'h0, c != 3}, "ref active");
    end
    wr_reg(8'h84, 8'h11);
    chk({13'h0, r_pd}, 14'h0001, "ref power off");
    chk({11'h0, r_mul}, 14'h0000, "pd multiplier");
    chk({13'h0, r_act}, 14'h0000, "pd inactive");
  endtask : ref_rates

  task automatic strobe_hys;
    wr_reg(8'h88, 8'h0E);
    chk({4'h0, h_amt}, 14'h0200, "amount high");
    chk({12'h0, h_on, h_rise}, 14'h0003, "strobe bits");
    wr_reg(8'h89, 8'h2C);
    chk({4'h0, h_amt}, 14'h022C, "amount full");
    chk(h_mv, 14'h15B8, "hysteresis mv");
    wr_reg(8'h88, 8'h02);
    chk({12'h0, h_on, h_rise}, 14'h0000, "strobe off");
    chk(h_mv, 14'h0000, "hysteresis gated");
  endtask : strobe_hys

  task automatic cross_loop;
    wr_reg(8'h83, 8'h0A);
    chk({9'h0, c_on, c_val}, 14'h000A, "crossing");
    wr_reg(8'h90, 8'h0A);
    chk({9'h0, f_dc, f_xc, k_dc, k_xc, l_pd}, 14'h000A, "loop");
  endtask : cross_loop

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial begin
    rst   = 1'b1;
    addr  = 8'h00;
    wr    = 1'b0;
    wdata = 8'h00;
    rd    = 1'b0;
    reset_values();
    reserved_bits();
    duty_trim();
    ref_rates();
    strobe_hys();
    cross_loop();
    reset_values();
    end_of_test();
  end

  initial begin
    #200us;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : dct_clock_tuning_regs_tb_top
